// [scsr_pkg.sv]
/*
 * Constants, field layouts and carrier types for the configuration and
 * status register bank. Assumes a 32-bit classic Wishbone slave port
 * in which register index N sits at byte address 4*N.
 */
`default_nettype none
package scsr_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [9:0] IDX_L2_CTL = 10'h11E;
	localparam logic [9:0] IDX_SYSENTER_CS = 10'h174;
	localparam logic [9:0] IDX_SYSENTER_SP = 10'h175;
	localparam logic [9:0] IDX_SYSENTER_IP = 10'h176;
	localparam logic [9:0] IDX_MC_CAP = 10'h179;
	localparam logic [9:0] IDX_MC_STATUS = 10'h17A;
	localparam logic [9:0] IDX_EVTSEL0 = 10'h186;
	localparam logic [9:0] IDX_EVTSEL1 = 10'h187;
	localparam logic [9:0] IDX_PSTATE_STAT = 10'h198;
	localparam logic [9:0] IDX_PSTATE_CTL = 10'h199;
	localparam logic [9:0] IDX_CLK_MOD = 10'h19A;
	localparam logic [9:0] IDX_THERM_INT = 10'h19B;
	localparam logic [9:0] IDX_HIGH_HALF = 10'h1F0;
	localparam logic [9:0] IDX_IRQ_STATUS = 10'h1F1;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h1F2;

	// L2 control fields.
	localparam int L2_HW_EN_BIT = 0;
	localparam int L2_ECC_CHK_BIT = 5;
	localparam int L2_INIT_BIT = 8;
	localparam int L2_ABSENT_BIT = 23;

	// Machine-check capability and status fields.
	localparam int CAP_CTL_PRESENT_BIT = 8;
	localparam int MCS_RESTART_BIT = 0;
	localparam int MCS_EIPV_BIT = 1;
	localparam int MCS_IN_PROGRESS_BIT = 2;

	// Clock modulation and thermal interrupt fields.
	localparam int CLKMOD_DUTY_LSB = 1;
	localparam int CLKMOD_EN_BIT = 4;
	localparam int THERM_HI_EN_BIT = 0;
	localparam int THERM_LO_EN_BIT = 1;

	// Interrupt status bits.
	localparam int IRQ_MC_RAISED = 0;
	localparam int IRQ_SHUTDOWN = 1;
	localparam int IRQ_IGNORED = 2;
	localparam int IRQ_THERM = 3;
	localparam int IRQ_BITS = 4;

	// Reset values.
	localparam logic [63:0] RST_ZERO64 = 64'h0000_0000_0000_0000;
	localparam logic [15:0] RST_PSTATE = 16'h0000;
	localparam logic [3:0] RST_IRQ = 4'h0;

	typedef struct packed {
		logic raise;
		logic restart_pointer_valid;
		logic eipv;
	} scsr_mc_event_t;

	typedef struct packed {
		logic enable;
		logic [2:0] duty;
	} scsr_clkmod_t;
endpackage

`default_nettype wire

// [scsr_regs.sv]
/*
 * Configuration and status register bank: L2 control, machine-check
 * capability and status, performance-state, clock modulation, thermal
 * interrupt control, fast system-call and event-select registers.
 * Assumes the core drives the event inputs synchronously to clk_i and
 * that the flush pin is asynchronous. The 64-bit registers are reached
 * through a 32-bit classic Wishbone port with a high-half holding word.
 */
// Decided for this implementation: the Wishbone register port.
//
// Behaviour
// - L2 control bit 0 reads 1 when the cache is hardware-enabled.
// - L2 control bit 5 enables ECC checking, default off.
// - Check bits are always generated on cache writes.
// - L2 control bit 8 is writable, resets 0, marks cache initialized.
// - Until initialized, write-back-invalidate and flush pin are ignored.
// - L2 control bit 23 reads 1 when no L2 cache is present.
// - Capability bits 7:0 report the number of error-reporting banks.
// - Capability bit 8 reports the global control register at 17BH.
// - Status bit 0 shows the saved pointer can restart the program.
// - Status bit 1 shows the saved instruction caused the error.
// - Raising a machine check sets the in-progress flag, bit 2.
// - A machine check while in progress enters shutdown instead.
// - Performance status bits 15:0 show the active state value.
// - Performance control bits 15:0 hold the target; upper bits reserved.
// - Clock modulation register enables modulation and selects duty.
// - Thermal interrupt register enables interrupts on transitions.
`timescale 1ns/1ns
`default_nettype none

module scsr_regs #(
	parameter logic [7:0] MC_BANK_COUNT = 8'h05,
	parameter bit MC_CTL_PRESENT = 1'b1
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Cache status and requests.
	input wire logic l2_hw_enabled_i,
	input wire logic l2_absent_i,
	input wire logic writeback_invalidate_instruction_i,
	input wire logic flush_n_i,
	output logic writeback_invalidate_go_o,
	output logic flush_go_o,
	output logic ecc_check_en_o,
	output logic ecc_generate_en_o,
	// Machine check.
	input wire scsr_pkg::scsr_mc_event_t mc_event_i,
	output logic machine_check_exception_o,
	output logic shutdown_o,
	// Power and thermal.
	input wire logic [15:0] perf_state_i,
	input wire logic thermal_hi_i,
	input wire logic thermal_lo_i,
	output logic [15:0] perf_target_o,
	output scsr_pkg::scsr_clkmod_t clkmod_o,
	output logic thermal_irq_o,
	// Interrupt.
	output logic irq_o
);
	logic ack_q;
	logic [31:0] rdat_q;
	logic [31:0] rdat_d;
	logic [31:0] hi_q;
	logic wr_fire;
	logic rd_fire;
	logic [9:0] idx;
	logic mapped;
	logic ecc_chk_q;
	logic l2_init_q;
	logic [63:0] sys_cs_q;
	logic [63:0] sys_sp_q;
	logic [63:0] sys_ip_q;
	logic [63:0] evtsel0_q;
	logic [63:0] evtsel1_q;
	logic restart_pointer_valid_q;
	logic eipv_q;
	logic machine_check_in_progress_q;
	logic shutdown_q;
	logic mce_q;
	logic [15:0] pstate_ctl_q;
	scsr_pkg::scsr_clkmod_t clkmod_q;
	logic [1:0] therm_en_q;
	logic therm_irq_q;
	logic therm_hi_q;
	logic therm_lo_q;
	logic [2:0] flush_sync_q;
	logic wbi_go_q;
	logic flush_go_q;
	logic [3:0] irq_stat_q;
	logic [3:0] irq_mask_q;
	logic [3:0] irq_evt;
	logic irq_q;
	logic flush_req;
	logic therm_evt;

	// Applies byte enables to the low word of a register.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat,
			input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[8*b +: 8] = dat[8*b +: 8];
			end
		end
		return res;
	endfunction

	// Writing the low word commits the held high half as well.
	function automatic logic [63:0] wr64(input logic [63:0] old, input logic [31:0] hi,
			input logic [31:0] dat, input logic [3:0] sel);
		return {hi, merge(old[31:0], dat, sel)};
	endfunction

	assign idx = wb_adr_i[11:2];
	assign mapped = (wb_adr_i[31:12] == 20'h00000) && (wb_adr_i[1:0] == 2'b00);
	assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && mapped;
	assign rd_fire = wb_cyc_i && wb_stb_i && !wb_we_i && ack_q && mapped;

	// Unmapped addresses are still acknowledged, so a stray access cannot hang the bus.
	// Ack one cycle after the strobe; writes land at the ack edge.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	// Read mux; unmapped and reserved bits read zero.
	always_comb begin
		rdat_d = 32'h0000_0000;
		if (mapped) begin
			unique case (idx)
				scsr_pkg::IDX_L2_CTL: begin
					rdat_d[scsr_pkg::L2_HW_EN_BIT] = l2_hw_enabled_i;
					rdat_d[scsr_pkg::L2_ECC_CHK_BIT] = ecc_chk_q;
					rdat_d[scsr_pkg::L2_INIT_BIT] = l2_init_q;
					rdat_d[scsr_pkg::L2_ABSENT_BIT] = l2_absent_i;
				end
				scsr_pkg::IDX_SYSENTER_CS: rdat_d = sys_cs_q[31:0];
				scsr_pkg::IDX_SYSENTER_SP: rdat_d = sys_sp_q[31:0];
				scsr_pkg::IDX_SYSENTER_IP: rdat_d = sys_ip_q[31:0];
				scsr_pkg::IDX_MC_CAP: begin
					rdat_d[7:0] = MC_BANK_COUNT;
					rdat_d[scsr_pkg::CAP_CTL_PRESENT_BIT] = MC_CTL_PRESENT;
				end
				scsr_pkg::IDX_MC_STATUS: begin
					rdat_d[scsr_pkg::MCS_RESTART_BIT] = restart_pointer_valid_q;
					rdat_d[scsr_pkg::MCS_EIPV_BIT] = eipv_q;
					rdat_d[scsr_pkg::MCS_IN_PROGRESS_BIT] = machine_check_in_progress_q;
				end
				scsr_pkg::IDX_EVTSEL0: rdat_d = evtsel0_q[31:0];
				scsr_pkg::IDX_EVTSEL1: rdat_d = evtsel1_q[31:0];
				scsr_pkg::IDX_PSTATE_STAT: rdat_d[15:0] = perf_state_i;
				scsr_pkg::IDX_PSTATE_CTL: rdat_d[15:0] = pstate_ctl_q;
				scsr_pkg::IDX_CLK_MOD: begin
					rdat_d[scsr_pkg::CLKMOD_EN_BIT] = clkmod_q.enable;
					rdat_d[scsr_pkg::CLKMOD_DUTY_LSB +: 3] = clkmod_q.duty;
				end
				scsr_pkg::IDX_THERM_INT: rdat_d[1:0] = therm_en_q;
				scsr_pkg::IDX_HIGH_HALF: rdat_d = hi_q;
				scsr_pkg::IDX_IRQ_STATUS: rdat_d[3:0] = irq_stat_q;
				scsr_pkg::IDX_IRQ_MASK: rdat_d[3:0] = irq_mask_q;
				default: rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0000_0000;
		end else if (wb_cyc_i && wb_stb_i && !ack_q) begin
			// Read data is taken on the request edge and stands until the next access.
			rdat_q <= rdat_d;
		end
	end

	// High-half holding word: reads latch the upper half, writes preload it.
	// Software reads the low word first, since that read refreshes the holding word.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hi_q <= 32'h0000_0000;
		end else if (wr_fire && idx == scsr_pkg::IDX_HIGH_HALF) begin
			hi_q <= merge(hi_q, wb_dat_i, wb_sel_i);
		end else if (rd_fire) begin
			unique case (idx)
				scsr_pkg::IDX_SYSENTER_CS: hi_q <= sys_cs_q[63:32];
				scsr_pkg::IDX_SYSENTER_SP: hi_q <= sys_sp_q[63:32];
				scsr_pkg::IDX_SYSENTER_IP: hi_q <= sys_ip_q[63:32];
				scsr_pkg::IDX_EVTSEL0: hi_q <= evtsel0_q[63:32];
				scsr_pkg::IDX_EVTSEL1: hi_q <= evtsel1_q[63:32];
				scsr_pkg::IDX_HIGH_HALF: hi_q <= hi_q;
				default: hi_q <= 32'h0000_0000;
			endcase
		end
	end

	// Plain read-write 64-bit registers.
	// The low-word write commits both halves at once, so no half-written value is seen.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sys_cs_q <= scsr_pkg::RST_ZERO64;
			sys_sp_q <= scsr_pkg::RST_ZERO64;
			sys_ip_q <= scsr_pkg::RST_ZERO64;
			evtsel0_q <= scsr_pkg::RST_ZERO64;
			evtsel1_q <= scsr_pkg::RST_ZERO64;
		end else if (wr_fire) begin
			if (idx == scsr_pkg::IDX_SYSENTER_CS) sys_cs_q <= wr64(sys_cs_q, hi_q, wb_dat_i, wb_sel_i);
			if (idx == scsr_pkg::IDX_SYSENTER_SP) sys_sp_q <= wr64(sys_sp_q, hi_q, wb_dat_i, wb_sel_i);
			if (idx == scsr_pkg::IDX_SYSENTER_IP) sys_ip_q <= wr64(sys_ip_q, hi_q, wb_dat_i, wb_sel_i);
			if (idx == scsr_pkg::IDX_EVTSEL0) evtsel0_q <= wr64(evtsel0_q, hi_q, wb_dat_i, wb_sel_i);
			if (idx == scsr_pkg::IDX_EVTSEL1) evtsel1_q <= wr64(evtsel1_q, hi_q, wb_dat_i, wb_sel_i);
		end
	end

	// Cache control; read-only bits 0 and 23 are never stored.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ecc_chk_q <= 1'b0;
			l2_init_q <= 1'b0;
		end else if (wr_fire && idx == scsr_pkg::IDX_L2_CTL) begin
			if (wb_sel_i[0]) ecc_chk_q <= wb_dat_i[scsr_pkg::L2_ECC_CHK_BIT];
			if (wb_sel_i[1]) l2_init_q <= wb_dat_i[scsr_pkg::L2_INIT_BIT];
		end
	end

	// The flush pin is asynchronous, so it is synchronised before use.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			flush_sync_q <= 3'b111;
		end else begin
			flush_sync_q <= {flush_sync_q[1:0], flush_n_i};
		end
	end
	assign flush_req = flush_sync_q[2] && !flush_sync_q[1];

	// Requests are dropped, not deferred, while the cache is uninitialized.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wbi_go_q <= 1'b0;
			flush_go_q <= 1'b0;
		end else begin
			wbi_go_q <= writeback_invalidate_instruction_i && l2_init_q;
			flush_go_q <= flush_req && l2_init_q;
		end
	end

	// Machine-check status and shutdown.
	// Shutdown is left only through reset, so a nested check is never lost.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			restart_pointer_valid_q <= 1'b0;
			eipv_q <= 1'b0;
			machine_check_in_progress_q <= 1'b0;
			shutdown_q <= 1'b0;
			mce_q <= 1'b0;
		end else begin
			mce_q <= 1'b0;
			if (wr_fire && idx == scsr_pkg::IDX_MC_STATUS && wb_sel_i[0]) begin
				restart_pointer_valid_q <= wb_dat_i[scsr_pkg::MCS_RESTART_BIT];
				eipv_q <= wb_dat_i[scsr_pkg::MCS_EIPV_BIT];
				machine_check_in_progress_q <= wb_dat_i[scsr_pkg::MCS_IN_PROGRESS_BIT];
			end
			if (mc_event_i.raise) begin
				if (machine_check_in_progress_q) begin
					shutdown_q <= 1'b1;
				end else begin
					restart_pointer_valid_q <= mc_event_i.restart_pointer_valid;
					eipv_q <= mc_event_i.eipv;
					machine_check_in_progress_q <= 1'b1;
					mce_q <= 1'b1;
				end
			end
		end
	end

	// Power and thermal control registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pstate_ctl_q <= scsr_pkg::RST_PSTATE;
			clkmod_q <= '0;
			therm_en_q <= 2'b00;
		end else if (wr_fire) begin
			if (idx == scsr_pkg::IDX_PSTATE_CTL) begin
				pstate_ctl_q <= 16'(merge({16'h0000, pstate_ctl_q}, wb_dat_i, wb_sel_i));
			end
			if (idx == scsr_pkg::IDX_CLK_MOD && wb_sel_i[0]) begin
				clkmod_q.enable <= wb_dat_i[scsr_pkg::CLKMOD_EN_BIT];
				clkmod_q.duty <= wb_dat_i[scsr_pkg::CLKMOD_DUTY_LSB +: 3];
			end
			if (idx == scsr_pkg::IDX_THERM_INT && wb_sel_i[0]) begin
				therm_en_q <= wb_dat_i[1:0];
			end
		end
	end

	// Rising edges of the thermal indications, gated by their enables.
	// A level that stays high raises one interrupt, not one per cycle.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			therm_hi_q <= 1'b0;
			therm_lo_q <= 1'b0;
			therm_irq_q <= 1'b0;
		end else begin
			therm_hi_q <= thermal_hi_i;
			therm_lo_q <= thermal_lo_i;
			therm_irq_q <= therm_evt;
		end
	end
	assign therm_evt = (thermal_hi_i && !therm_hi_q && therm_en_q[scsr_pkg::THERM_HI_EN_BIT])
		|| (thermal_lo_i && !therm_lo_q && therm_en_q[scsr_pkg::THERM_LO_EN_BIT]);

	// Sticky interrupt status; a new event wins over a same-cycle clear.
	always_comb begin
		irq_evt = 4'h0;
		irq_evt[scsr_pkg::IRQ_MC_RAISED] = mc_event_i.raise && !machine_check_in_progress_q;
		irq_evt[scsr_pkg::IRQ_SHUTDOWN] = mc_event_i.raise && machine_check_in_progress_q;
		irq_evt[scsr_pkg::IRQ_IGNORED] = !l2_init_q && (writeback_invalidate_instruction_i
			|| flush_req);
		irq_evt[scsr_pkg::IRQ_THERM] = therm_evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= scsr_pkg::RST_IRQ;
			irq_mask_q <= scsr_pkg::RST_IRQ;
			irq_q <= 1'b0;
		end else begin
			if (wr_fire && idx == scsr_pkg::IDX_IRQ_STATUS && wb_sel_i[0]) begin
				irq_stat_q <= (irq_stat_q & ~wb_dat_i[3:0]) | irq_evt;
			end else begin
				irq_stat_q <= irq_stat_q | irq_evt;
			end
			if (wr_fire && idx == scsr_pkg::IDX_IRQ_MASK && wb_sel_i[0]) begin
				irq_mask_q <= wb_dat_i[3:0];
			end
			// Registered for a clean output, so the line follows the status one cycle late.
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// Check-bit generation has no off switch.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ecc_generate_en_o <= 1'b1;
		end else begin
			ecc_generate_en_o <= 1'b1;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign writeback_invalidate_go_o = wbi_go_q;
	assign flush_go_o = flush_go_q;
	assign ecc_check_en_o = ecc_chk_q;
	assign machine_check_exception_o = mce_q;
	assign shutdown_o = shutdown_q;
	assign perf_target_o = pstate_ctl_q;
	assign clkmod_o = clkmod_q;
	assign thermal_irq_o = therm_irq_q;
	assign irq_o = irq_q;
endmodule

`default_nettype wire

// [scsr_checker.sv]
/* Port assertions for the register bank.
 Assumes one clock with a synchronous active-high reset. */
`timescale 1ns/1ns
`default_nettype none
module scsr_checker (
	// Clock, reset and bus.
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// Events and controls.
	input wire logic writeback_invalidate_instruction_i,
	input wire logic flush_n_i,
	input wire logic writeback_invalidate_go_o,
	input wire logic flush_go_o,
	input wire logic ecc_generate_en_o,
	input wire scsr_pkg::scsr_mc_event_t mc_event_i,
	input wire logic machine_check_exception_o,
	input wire logic shutdown_o,
	input wire logic thermal_hi_i,
	input wire logic thermal_lo_i,
	input wire logic thermal_irq_o,
	input wire logic [15:0] perf_target_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	a_bus_answer: assert property (s_req |=> s_ans)
		else $error("Bus request not answered by one ack pulse.");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("Ack without a request.");
	a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[31:12] != 20'h0
		|-> wb_dat_o == 32'h0) else $error("Unmapped read not zero.");
	a_ecc_gen_on: assert property (ecc_generate_en_o)
		else $error("Check bit generation off.");
	a_shutdown_sticky: assert property (shutdown_o |=> shutdown_o)
		else $error("Shutdown left without reset.");
	a_exc_cause: assert property (machine_check_exception_o |-> $past(mc_event_i.raise))
		else $error("Exception without an event.");
	a_wbi_go_cause: assert property (writeback_invalidate_go_o
		|-> $past(writeback_invalidate_instruction_i)) else $error("Stray write-back.");
	a_flush_cause: assert property (flush_go_o |-> !$past(flush_n_i, 3))
		else $error("Flush without a pin fall.");
	a_therm_cause: assert property (thermal_irq_o |-> $past(thermal_hi_i || thermal_lo_i))
		else $error("Thermal interrupt without a transition.");
	a_target_write: assert property (!$past(rst_i) && $changed(perf_target_o)
		|-> $past(wb_cyc_i && wb_we_i)) else $error("Target moved without a write.");
endmodule
bind scsr_regs scsr_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_dat_o, .wb_ack_o, .writeback_invalidate_instruction_i, .flush_n_i,
	.writeback_invalidate_go_o, .flush_go_o, .ecc_generate_en_o, .mc_event_i,
	.machine_check_exception_o, .shutdown_o, .thermal_hi_i, .thermal_lo_i,
	.thermal_irq_o, .perf_target_o);
`default_nettype wire

// [scsr_regs_bench.sv]
/* Self-checking bench for the register bank.
 Assumes the bank answers each Wishbone cycle with one ack pulse. */
`timescale 1ns/1ns
`default_nettype none
module scsr_regs_bench;
	localparam logic [7:0] NB = 8'hB3;
	logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, hw = 1, ab = 0, wbi = 0, fln = 1;
	logic thi = 0, tlo = 0, ack, wgo, fgo, eccc, ecce, exc, shut, tirq, irq;
	logic [31:0] adr = 32'h0, wd = 32'h0, rd, got;
	logic [3:0] sel = 4'hF;
	logic [15:0] pst = 16'h0, ptgt;
	logic [63:0] v, r;
	scsr_pkg::scsr_mc_event_t mce = '0;
	scsr_pkg::scsr_clkmod_t cm;
	int error_cnt = 0, num_checks = 0, cn = 0, n_w = 0, n_f = 0, n_e = 0, n_t = 0;
	logic [9:0] rw_idx [5] = '{scsr_pkg::IDX_SYSENTER_CS, scsr_pkg::IDX_SYSENTER_SP,
		scsr_pkg::IDX_SYSENTER_IP, scsr_pkg::IDX_EVTSEL0, scsr_pkg::IDX_EVTSEL1};
	scsr_regs #(.MC_BANK_COUNT(NB), .MC_CTL_PRESENT(1'b1)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack), .l2_hw_enabled_i(hw),
		.l2_absent_i(ab), .writeback_invalidate_instruction_i(wbi), .flush_n_i(fln),
		.writeback_invalidate_go_o(wgo), .flush_go_o(fgo), .ecc_check_en_o(eccc),
		.ecc_generate_en_o(ecce), .mc_event_i(mce), .machine_check_exception_o(exc),
		.shutdown_o(shut), .perf_state_i(pst), .thermal_hi_i(thi), .thermal_lo_i(tlo),
		.perf_target_o(ptgt), .clkmod_o(cm), .thermal_irq_o(tirq), .irq_o(irq));
	always #10 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cn <= cn + 1;
		n_w <= n_w + wgo;
		n_f <= n_f + fgo;
		n_e <= n_e + exc;
		n_t <= n_t + tirq;
		if (cn == 6000) begin
			error_cnt++;
			complete_run();
		end
	end
	function automatic logic [31:0] af(input logic [9:0] i);
		return {20'h0, i, 2'h0};
	endfunction
	function automatic logic [63:0] l2x(input logic h, input logic a, input logic [63:0] w);
		return {40'h0, a, 14'h0, w[8], 2'h0, w[5], 4'h0, h};
	endfunction
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		num_checks++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clk_i);
		cyc <= 1;
		we <= w;
		adr <= a;
		wd <= d;
		@(posedge clk_i);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge clk_i);
			k++;
		end
		if (k == 20) error_cnt++;
		got = rd;
		cyc <= 0;
		we <= 0;
	endtask
	task automatic wr64(input logic [9:0] i, input logic [63:0] x);
		wb(1, af(scsr_pkg::IDX_HIGH_HALF), x[63:32]);
		wb(1, af(i), x[31:0]);
	endtask
	task automatic rd64(input logic [9:0] i);
		wb(0, af(i), 32'h0);
		r[31:0] = got;
		wb(0, af(scsr_pkg::IDX_HIGH_HALF), 32'h0);
		r[63:32] = got;
	endtask
	task automatic kick;
		@(posedge clk_i);
		wbi <= 1;
		fln <= 0;
		@(posedge clk_i);
		wbi <= 0;
		repeat (8) @(posedge clk_i);
		fln <= 1;
		repeat (8) @(posedge clk_i);
	endtask
	task automatic mc(input logic [1:0] b);
		@(posedge clk_i);
		mce <= {1'b1, b[0], b[1]};
		@(posedge clk_i);
		mce <= '0;
		repeat (3) @(posedge clk_i);
	endtask
	task complete_run;
		$display("checks=%0d errors=%0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		void'($urandom(32));
		repeat (20) @(posedge clk_i);
		rst_i <= 0;
		for (int i = 0; i < 4; i++) begin
			hw <= i[0];
			ab <= i[1];
			rd64(scsr_pkg::IDX_L2_CTL);
			chk(r, l2x(i[0], i[1], 64'h0));
		end
		kick;
		chk(64'(n_w + n_f), 64'h0);
		v = {$urandom, $urandom} | 64'h120;
		wr64(scsr_pkg::IDX_L2_CTL, v);
		rd64(scsr_pkg::IDX_L2_CTL);
		chk(r, l2x(1'b1, 1'b1, v));
		chk(64'(eccc), 64'h1);
		kick;
		chk(64'(n_w + 2 * n_f), 64'h3);
		chk(64'(ecce), 64'h1);
		sel <= 4'h2;
		wr64(scsr_pkg::IDX_L2_CTL, 64'h0);
		sel <= 4'hF;
		rd64(scsr_pkg::IDX_L2_CTL);
		chk(r, l2x(1'b1, 1'b1, 64'h20));
		chk(64'(eccc), 64'h1);
		wr64(scsr_pkg::IDX_MC_CAP, '1);
		rd64(scsr_pkg::IDX_MC_CAP);
		chk(r, {55'h0, 1'b1, NB});
		v = {$urandom, $urandom};
		mc(v[1:0]);
		rd64(scsr_pkg::IDX_MC_STATUS);
		chk(r, {61'h0, 1'b1, v[1:0]});
		wr64(scsr_pkg::IDX_MC_STATUS, 64'h0);
		mc(2'h3);
		chk(64'(n_e + 2 * shut), 64'h2);
		mc(2'h0);
		chk(64'(n_e + 2 * shut), 64'h4);
		pst <= 16'($urandom);
		rd64(scsr_pkg::IDX_PSTATE_STAT);
		chk(r, {48'h0, pst});
		wr64(scsr_pkg::IDX_PSTATE_CTL, v);
		rd64(scsr_pkg::IDX_PSTATE_CTL);
		chk(r, {48'h0, v[15:0]});
		chk(64'(ptgt), 64'(v[15:0]));
		wr64(scsr_pkg::IDX_CLK_MOD, v);
		rd64(scsr_pkg::IDX_CLK_MOD);
		chk(r, v & 64'h1E);
		chk(64'({cm.enable, cm.duty}), 64'(v[4:1]));
		wr64(scsr_pkg::IDX_THERM_INT, 64'h1);
		thi <= 1;
		tlo <= 1;
		repeat (4) @(posedge clk_i);
		rd64(scsr_pkg::IDX_THERM_INT);
		chk(r, 64'h1);
		chk(64'(n_t), 64'h1);
		foreach (rw_idx[i]) begin
			v = {$urandom, $urandom};
			wr64(rw_idx[i], v);
			rd64(rw_idx[i]);
			chk(r, v);
		end
		wb(0, 32'h0000_1478, 32'h0);
		chk(64'(got), 64'h0);
		wb(0, af(scsr_pkg::IDX_L2_CTL) | 32'h2, 32'h0);
		chk(64'(got), 64'h0);
		rd64(scsr_pkg::IDX_IRQ_STATUS);
		chk(r, 64'hF);
		chk(64'(irq), 64'h0);
		wb(1, af(scsr_pkg::IDX_IRQ_MASK), 32'h4);
		repeat (2) @(posedge clk_i);
		chk(64'(irq), 64'h1);
		wb(1, af(scsr_pkg::IDX_IRQ_STATUS), 32'h4);
		repeat (2) @(posedge clk_i);
		rd64(scsr_pkg::IDX_IRQ_STATUS);
		chk(r, 64'hB);
		chk(64'(irq), 64'h0);
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rd64(scsr_pkg::IDX_L2_CTL);
		chk(r, l2x(1'b1, 1'b1, 64'h0));
		chk(64'(shut), 64'h0);
		chk(64'(ecce), 64'h1);
		complete_run();
	end
endmodule
`default_nettype wire
